// File: shared/iopcb_pkg.sv
// constants, register map and carrier types for the port and clock block cluster
`default_nettype none

package iopcb_pkg;

   // ==========================================================================
   // sizes
   localparam int NPORT = 6;
   localparam int NPIN = 32;
   localparam int NCB = 6;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam int CW = 16;
   localparam int SW = 6;

   // port widths and first pin, narrowest first
   localparam int PORT_W [NPORT] = '{1, 1, 4, 8, 16, 32};
   localparam int PORT_PIN0 [NPORT] = '{0, 1, 0, 0, 0, 0};

   // pins taken by the serial link when it is enabled
   localparam int LINK_PIN_LO = 24;
   localparam int LINK_PIN_HI = 31;

   // ==========================================================================
   // register map (word addresses)
   localparam logic [1:0] REGION_PORT = 2'h0;
   localparam logic [1:0] REGION_CB = 2'h1;
   localparam logic [AW-1:0] LINK_ADDR = 8'h80;

   localparam logic [2:0] REG_CTRL = 3'h0;
   localparam logic [2:0] REG_DATA = 3'h1;
   localparam logic [2:0] REG_COND = 3'h2;
   localparam logic [2:0] REG_TIME = 3'h3;
   localparam logic [2:0] REG_STAMP = 3'h4;
   localparam logic [2:0] REG_STATUS = 3'h5;

   localparam logic REG_CB_CFG = 1'b0;
   localparam logic REG_CB_DIV = 1'b1;

   // ==========================================================================
   // carriers
   typedef enum logic [1:0] {
      COND_NONE = 2'h0,
      COND_EQ = 2'h1,
      COND_NE = 2'h2
   } iopcb_cond_e;

   typedef struct packed {
      logic en;
      logic dir_out;
      logic open_drain;
      logic strobe_en;
      iopcb_cond_e cond;
      logic [2:0] clk_sel;
   } iopcb_port_cfg_s;

   typedef struct packed {
      logic from_pin;
      logic pin_sel;
      logic [7:0] div;
   } iopcb_cb_cfg_s;

   localparam int CTRL_BITS = $bits(iopcb_port_cfg_s);
   localparam int CB_BITS = $bits(iopcb_cb_cfg_s);
   localparam iopcb_port_cfg_s PORT_CFG_RESET = '0;
   localparam iopcb_cb_cfg_s CB_CFG_RESET = '0;
   localparam logic [CW-1:0] COUNT_RESET = 16'h0000;

endpackage : iopcb_pkg

`default_nettype wire

// File: rtl/iopcb_top.sv
// programmable pin ports with serialiser, port counters, strobes and clock blocks
`default_nettype none

module iopcb_top
   import iopcb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [DW-1:0] rd_data_o,
   output logic core_stall_o,
   input wire logic [NPIN-1:0] pin_i,
   output logic [NPIN-1:0] pin_o,
   output logic [NPIN-1:0] pin_oe_o,
   output logic [NPIN-1:0] pin_pulldown_property_o,
   input wire logic [NPORT-1:0] input_strobe_i,
   output logic [NPORT-1:0] output_strobe_o,
   output logic [NPORT-1:0] event_o,
   output logic link_en_o
);

   // ==========================================================================
   // helpers
   function automatic logic [DW-1:0] width_mask(input int p);
      logic [DW-1:0] m;
      m = '1;
      if (PORT_W[p] < DW) begin
         m = DW'((64'h1 << PORT_W[p]) - 64'h1);
      end
      return m;
   endfunction : width_mask

   function automatic logic [DW-1:0] pin_bits(input int p, input logic [NPIN-1:0] pins);
      return (DW'(pins) >> PORT_PIN0[p]) & width_mask(p);
   endfunction : pin_bits

   function automatic logic [SW-1:0] last_slice(input int p);
      return SW'((DW / PORT_W[p]) - 1);
   endfunction : last_slice

   // ==========================================================================
   // register bus decode
   wire logic in_port_region = (addr_i[7:6] == REGION_PORT) && (int'(addr_i[5:3]) < NPORT);
   wire logic in_cb_region = (addr_i[7:6] == REGION_CB) && (int'(addr_i[3:1]) < NCB);
   wire logic [2:0] port_sel = addr_i[5:3];
   wire logic [2:0] reg_sel = addr_i[2:0];
   wire logic [2:0] cb_sel = addr_i[3:1];
   wire logic cb_reg = addr_i[0];
   wire logic is_link = (addr_i == LINK_ADDR);

   // ==========================================================================
   // state
   iopcb_port_cfg_s cfg [NPORT];
   iopcb_cb_cfg_s cbc [NCB];
   logic [DW-1:0] xfer [NPORT];
   logic [DW-1:0] shreg [NPORT];
   logic [DW-1:0] cond_val [NPORT];
   logic [DW-1:0] out_val [NPORT];
   logic [CW-1:0] count [NPORT];
   logic [CW-1:0] stamp [NPORT];
   logic [CW-1:0] when [NPORT];
   logic [SW-1:0] slice [NPORT];
   logic [NPORT-1:0] full;
   logic [NPORT-1:0] armed;
   logic [NCB-1:0] cb_tick;
   logic [NPORT-1:0] stall_hit;
   logic [NPORT-1:0] rd_ok;
   logic link_en;

   // ==========================================================================
   // clock blocks
   // reference tick
   assign cb_tick[0] = 1'b1;

   for (genvar c = 1; c < NCB; c++) begin : g_cb
      logic src_prev;
      logic [7:0] div_cnt;
      wire logic src_lvl = pin_i[PORT_PIN0[cbc[c].pin_sel]];
      wire logic src_edge = cbc[c].from_pin ? (src_lvl & ~src_prev) : 1'b1;
      wire logic div_wrap = (div_cnt == cbc[c].div);
      assign cb_tick[c] = src_edge & div_wrap;

      always_ff @(posedge ref_clk_i) begin
         if (rst_i) begin
            src_prev <= 1'b0;
            div_cnt <= 8'h00;
            cbc[c] <= CB_CFG_RESET;
         end else begin
            src_prev <= src_lvl;
            if (src_edge) begin
               div_cnt <= div_wrap ? 8'h00 : div_cnt + 8'h01;
            end
            if (wr_i && in_cb_region && int'(cb_sel) == c) begin
               if (cb_reg == REG_CB_CFG) begin
                  cbc[c].from_pin <= wr_data_i[0];
                  cbc[c].pin_sel <= wr_data_i[1];
               end else begin
                  cbc[c].div <= wr_data_i[7:0];
               end
            end
         end
      end
   end

   assign cbc[0] = CB_CFG_RESET;

   // ==========================================================================
   // ports
   for (genvar p = 0; p < NPORT; p++) begin : g_port
      localparam int W = PORT_W[p];
      wire logic sel = in_port_region && int'(port_sel) == p;
      wire logic ctrl_wr = wr_i && sel && reg_sel == REG_CTRL;
      wire logic data_wr = wr_i && sel && reg_sel == REG_DATA;
      wire logic data_rd = rd_i && sel && reg_sel == REG_DATA;
      wire logic cond_wr = wr_i && sel && reg_sel == REG_COND;
      wire logic time_wr = wr_i && sel && reg_sel == REG_TIME;
      wire logic tick = cfg[p].en && (int'(cfg[p].clk_sel) < NCB) && cb_tick[cfg[p].clk_sel];
      wire logic [DW-1:0] pv = pin_bits(p, pin_i);
      wire logic time_ok = ~armed[p] | (count[p] == when[p]);
      wire logic cond_ok = (cfg[p].cond == COND_NONE) ||
                           (cfg[p].cond == COND_EQ && pv == cond_val[p]) ||
                           (cfg[p].cond == COND_NE && pv != cond_val[p]);
      wire logic strobe_ok = ~cfg[p].strobe_en | input_strobe_i[p];
      wire logic in_fire = tick && !cfg[p].dir_out && time_ok && cond_ok && strobe_ok;
      wire logic in_done = in_fire && slice[p] == last_slice(p);
      wire logic [DW-1:0] in_word = (shreg[p] >> W) | (pv << (DW - W));
      wire logic out_load = tick && cfg[p].dir_out && slice[p] == '0 && full[p] && time_ok;
      wire logic out_step = tick && cfg[p].dir_out && slice[p] != '0;
      wire logic wr_ok = data_wr && cfg[p].dir_out && !full[p];
      assign rd_ok[p] = data_rd && !cfg[p].dir_out && full[p];
      assign stall_hit[p] = (data_wr && !wr_ok) || (data_rd && !rd_ok[p]);

      always_ff @(posedge ref_clk_i) begin
         if (rst_i) begin
            cfg[p] <= PORT_CFG_RESET;
            xfer[p] <= '0;
            shreg[p] <= '0;
            cond_val[p] <= '0;
            out_val[p] <= '0;
            count[p] <= COUNT_RESET;
            stamp[p] <= COUNT_RESET;
            when[p] <= COUNT_RESET;
            slice[p] <= '0;
            full[p] <= 1'b0;
            armed[p] <= 1'b0;
            output_strobe_o[p] <= 1'b0;
            event_o[p] <= 1'b0;
         end else begin
            count[p] <= count[p] + CW'(tick);
            // transfer register full flag, set wins
            full[p] <= (full[p] & ~rd_ok[p] & ~out_load) | in_done | wr_ok;
            event_o[p] <= in_done | (in_fire & cfg[p].cond != COND_NONE);
            output_strobe_o[p] <= out_load | out_step;
            if (ctrl_wr) begin
               cfg[p] <= iopcb_port_cfg_s'(wr_data_i[CTRL_BITS-1:0]);
            end else if (in_fire) begin
               cfg[p].cond <= COND_NONE;
            end
            if (cond_wr) begin
               cond_val[p] <= wr_data_i & width_mask(p);
            end
            if (time_wr) begin
               when[p] <= wr_data_i[CW-1:0];
               armed[p] <= 1'b1;
            end else if (in_fire || out_load) begin
               armed[p] <= 1'b0;
            end
            if (wr_ok) begin
               xfer[p] <= wr_data_i;
            end
            if (in_fire) begin
               shreg[p] <= in_word;
               slice[p] <= in_done ? '0 : slice[p] + SW'(1);
            end
            if (in_done) begin
               xfer[p] <= in_word;
            end
            if (out_load) begin
               out_val[p] <= xfer[p] & width_mask(p);
               shreg[p] <= xfer[p] >> W;
               slice[p] <= last_slice(p);
            end else if (out_step) begin
               out_val[p] <= shreg[p] & width_mask(p);
               shreg[p] <= shreg[p] >> W;
               slice[p] <= slice[p] - SW'(1);
            end
            if (in_done || out_load) begin
               stamp[p] <= count[p];
            end
         end
      end
   end

   // ==========================================================================
   // pin ownership and drive
   logic [NPIN-1:0] next_pin_o;
   logic [NPIN-1:0] next_pin_oe;
   logic [NPIN-1:0] owned;

   always_comb begin
      int own;
      logic bit_v;
      own = 0;
      bit_v = 1'b0;
      for (int i = 0; i < NPIN; i++) begin
         owned[i] = 1'b0;
         own = 0;
         for (int p = NPORT - 1; p >= 0; p--) begin
            if (cfg[p].en && i >= PORT_PIN0[p] && i < PORT_PIN0[p] + PORT_W[p]) begin
               owned[i] = 1'b1;
               own = p;
            end
         end
         if (link_en && i >= LINK_PIN_LO && i <= LINK_PIN_HI) begin
            owned[i] = 1'b0;
         end
         bit_v = out_val[own][i - PORT_PIN0[own]];
         next_pin_o[i] = bit_v & ~cfg[own].open_drain;
         next_pin_oe[i] = owned[i] & cfg[own].dir_out & (~cfg[own].open_drain | ~bit_v);
      end
   end

   // ==========================================================================
   // read mux
   logic [DW-1:0] next_rd_data;

   always_comb begin
      int p;
      int c;
      p = int'(port_sel);
      c = int'(cb_sel);
      next_rd_data = '0;
      if (in_port_region) begin
         case (reg_sel)
            REG_CTRL: next_rd_data = DW'(cfg[p]);
            REG_DATA: next_rd_data = rd_ok[p] ? xfer[p] : '0;
            REG_COND: next_rd_data = cond_val[p];
            REG_TIME: next_rd_data = DW'(count[p]);
            REG_STAMP: next_rd_data = DW'(stamp[p]);
            REG_STATUS: next_rd_data = DW'({slice[p], armed[p], full[p]});
            default: next_rd_data = '0;
         endcase
      end else if (in_cb_region) begin
         next_rd_data = (cb_reg == REG_CB_CFG) ? DW'({cbc[c].pin_sel, cbc[c].from_pin})
                                               : DW'(cbc[c].div);
      end else if (is_link) begin
         next_rd_data = DW'(link_en);
      end
   end

   // ==========================================================================
   // output registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         rd_data_o <= '0;
         core_stall_o <= 1'b0;
         pin_o <= '0;
         pin_oe_o <= '0;
         pin_pulldown_property_o <= '1;
         link_en <= 1'b0;
         link_en_o <= 1'b0;
      end else begin
         rd_data_o <= rd_i ? next_rd_data : '0;
         core_stall_o <= |stall_hit;
         pin_o <= next_pin_o;
         pin_oe_o <= next_pin_oe;
         pin_pulldown_property_o <= ~owned;
         if (wr_i && is_link) begin
            link_en <= wr_data_i[0];
         end
         link_en_o <= link_en;
      end
   end

endmodule : iopcb_top

`default_nettype wire

// File: dv/iopcb_top_asserts.sv
// assertion checker on the port cluster top ports
`default_nettype none
module iopcb_top_chk
   import iopcb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [AW-1:0] addr_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire logic [DW-1:0] rd_data_o,
   input wire logic core_stall_o,
   input wire logic [NPIN-1:0] pin_oe_o,
   input wire logic [NPIN-1:0] pin_pulldown_property_o,
   input wire logic [NPORT-1:0] output_strobe_o,
   input wire logic [NPORT-1:0] event_o,
   input wire logic link_en_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================================
   // bus answers
   // data only after a read
   AST_RD_IDLE: assert property (!$past(rd_i) |-> rd_data_o == '0)
      else $error("read data without read");
   AST_STALL_CAUSE: assert property (core_stall_o |-> $past(rd_i) || $past(wr_i))
      else $error("stall without access");
   AST_STALL_ZERO: assert property (core_stall_o |-> rd_data_o == '0)
      else $error("stall with read data");
   // ==========================================================================
   // reset and pins
   // pull-downs in reset
   AST_PD_RST: assert property (disable iff (1'b0) rst_i |=> &pin_pulldown_property_o)
      else $error("pull-down off in reset");
   AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> pin_oe_o == '0
      && output_strobe_o == '0 && event_o == '0 && !link_en_o && !core_stall_o)
      else $error("active output in reset");
   AST_OE_PD: assert property ((pin_oe_o & pin_pulldown_property_o) == '0)
      else $error("pull-down on driven pin");
   // link write shows two cycles later, with the pin release
   AST_LINK_WR: assert property (wr_i && addr_i == LINK_ADDR
      |=> ##1 link_en_o == $past(wr_data_i[0], 2))
      else $error("link enable not written");
   AST_LINK_OFF: assert property (link_en_o && $past(link_en_o) |-> pin_oe_o[31:24] == '0)
      else $error("port drives link pin");
endmodule : iopcb_top_chk
`default_nettype wire

// File: dv/iopcb_pins.sv
// pin-side model of the attached application hardware
`default_nettype none
module iopcb_pins
   import iopcb_pkg::*;
(
   input wire logic ref_clk_i,
   input wire logic [NPIN-1:0] drv_i,
   input wire logic [NPIN-1:0] drv_oe_i,
   input wire logic [NPIN-1:0] pd_i,
   input wire logic [NPIN-1:0] ext_val_i,
   input wire logic [NPIN-1:0] ext_oe_i,
   input wire logic ext_stb_i,
   output logic [NPIN-1:0] level_o,
   output logic [NPORT-1:0] strobe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [NPIN-1:0] noise = 32'h5555aaaa;
   // floating pins without pull wander every cycle
   always @(posedge ref_clk_i) noise <= ~noise;
   // external data on undriven pins, else pull-down or float
   assign level_o = (drv_oe_i & drv_i) | (~drv_oe_i & ext_oe_i & ext_val_i)
      | (~drv_oe_i & ~ext_oe_i & ~pd_i & noise);
   assign strobe_o = {NPORT{ext_stb_i}};
endmodule : iopcb_pins
`default_nettype wire

// File: dv/iopcb_top_test.sv
// self-checking bench for the port cluster top
`default_nettype none
module iopcb_top_test
   import iopcb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic ref_clk_i, rst_i, wr_i, rd_i, core_stall_o, link_en_o, ext_stb, rd_d, pin_d;
   logic [AW-1:0] addr_i;
   logic [DW-1:0] wr_data_i, rd_data_o, pin_i, pin_o, pin_oe_o, pd, ext_val, ext_oe, d;
   logic [NPORT-1:0] istb, output_strobe_o, event_o;
   logic [32:0] rq[$];
   logic [64:0] pq[$];
   logic [3:0] v;
   int errors, checks_done;

   iopcb_top dut_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
      .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
      .core_stall_o(core_stall_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o),
      .pin_pulldown_property_o(pd), .input_strobe_i(istb), .output_strobe_o(output_strobe_o),
      .event_o(event_o), .link_en_o(link_en_o));
   iopcb_pins pins_u (.ref_clk_i(ref_clk_i), .drv_i(pin_o), .drv_oe_i(pin_oe_o), .pd_i(pd),
      .ext_val_i(ext_val), .ext_oe_i(ext_oe), .ext_stb_i(ext_stb), .level_o(pin_i),
      .strobe_o(istb));

   initial begin
      ref_clk_i = 0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end
   // ==========================================================================
   // tasks
   task automatic bus(input logic r, input logic [7:0] a, input logic [31:0] w,
      input logic [32:0] e);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= w;
      wr_i <= !r;
      rd_i <= r;
      if (r) rq.push_back(e);
      @(posedge ref_clk_i);
      wr_i <= 0;
      rd_i <= 0;
   endtask : bus
   task automatic chk_rd(input logic [32:0] e);
      checks_done++;
      if ({core_stall_o, rd_data_o} !== e) begin
         errors++;
         $display("ERROR read exp %h seen %h", e, {core_stall_o, rd_data_o});
      end
   endtask : chk_rd
   task automatic chk_pin(input logic [64:0] e);
      logic [31:0] m, xo, xe;
      m = e[63:32];
      xo = e[64] ? '0 : e[31:0] & m;
      xe = e[64] ? ~e[31:0] & m : m;
      checks_done++;
      if ({pin_o & m, pin_oe_o} !== {xo, xe}) begin
         errors++;
         $display("ERROR pins exp %h seen %h", {xo, xe}, {pin_o & m, pin_oe_o});
      end
   endtask : chk_pin
   task automatic print_verdict();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   // ==========================================================================
   // monitor takes the oldest note when a result appears
   always @(posedge ref_clk_i) begin
      if (rd_d) chk_rd(rq.pop_front());
      if (pin_d) chk_pin(pq.pop_front());
      rd_d <= rd_i && !rst_i;
      pin_d <= output_strobe_o[5];
   end
   initial begin
      repeat (3000) @(posedge ref_clk_i);
      errors++;
      print_verdict();
   end
   // ==========================================================================
   // main sequence
   initial begin
      rst_i = 1;
      wr_i = 0;
      rd_i = 0;
      addr_i = '0;
      wr_data_i = '0;
      ext_val = '0;
      ext_oe = '0;
      ext_stb = 0;
      rd_d = 0;
      pin_d = 0;
      errors = 0;
      checks_done = 0;
      void'($urandom(32'hcdca));
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 0;
      for (int p = 0; p < NPORT; p++) bus(1, 8'(p * 8), '0, '0);
      bus(1, 8'h07, '0, '0);
      bus(1, 8'hff, '0, '0);
      for (int p = 0; p < NPORT; p++) begin
         d = $urandom & 32'h0fb;
         bus(0, 8'(p * 8), d, '0);
         bus(1, 8'(p * 8), '0, {1'b0, d});
         bus(0, 8'(p * 8), '0, '0);
      end
      v = 4'($urandom);
      ext_val <= {28'h0, v};
      ext_oe <= 32'h0000000f;
      bus(0, 8'h10, 32'h120, '0);
      repeat (40) @(posedge ref_clk_i);
      bus(1, 8'h11, '0, {1'b1, 32'h0});
      ext_stb <= 1;
      for (int i = 0; i < 50 && event_o[2] !== 1'b1; i++) @(negedge ref_clk_i);
      bus(1, 8'h11, '0, {1'b0, {8{v}}});
      bus(0, 8'h28, 32'h180, '0);
      d = $urandom;
      pq.push_back({1'b0, 32'hfffffff0, d});
      bus(0, 8'h29, d, '0);
      bus(1, 8'h29, '0, {1'b1, 32'h0});
      repeat (4) @(posedge ref_clk_i);
      bus(0, 8'h28, 32'h1c0, '0);
      d = $urandom;
      pq.push_back({1'b1, 32'hfffffff0, d});
      bus(0, 8'h29, d, '0);
      repeat (4) @(posedge ref_clk_i);
      bus(0, 8'h80, 32'h1, '0);
      bus(0, 8'h28, 32'h180, '0);
      d = $urandom;
      pq.push_back({1'b0, 32'h00fffff0, d});
      bus(0, 8'h29, d, '0);
      repeat (8) @(posedge ref_clk_i);
      // 8-bit input port on block zero: counter, slice state and timestamp
      bus(0, 8'h18, 32'h100, '0);
      bus(1, 8'h1b, '0, {1'b0, 32'h1});
      bus(1, 8'h1d, '0, {1'b0, 32'hc});
      bus(1, 8'h1c, '0, {1'b0, 32'h3});
      // block one divides by four and paces the 16-bit port counter
      bus(0, 8'h43, 32'h3, '0);
      bus(0, 8'h20, 32'h101, '0);
      for (int k = 0; k < 4; k++) bus(1, 8'h23, '0, {1'b0, 32'((k + 1) / 2)});
      repeat (4) @(posedge ref_clk_i);
      if (rq.size() + pq.size() != 0) begin
         errors++;
         $display("ERROR pending exp 0 seen %0d", rq.size() + pq.size());
      end
      print_verdict();
   end
endmodule : iopcb_top_test

bind iopcb_top iopcb_top_chk chk_u (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i),
   .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
   .core_stall_o(core_stall_o), .pin_oe_o(pin_oe_o),
   .pin_pulldown_property_o(pin_pulldown_property_o), .output_strobe_o(output_strobe_o),
   .event_o(event_o), .link_en_o(link_en_o));
`default_nettype wire
